/* include/apcd_consts.svh */
// Offsets, field layouts, reset values and fixed codes of the audio clock block
`ifndef APCD_CONSTS_SVH
`define APCD_CONSTS_SVH

// Register offsets on the control port
`define APCD_OFS_PREDIV      8'h14
`define APCD_OFS_INTEGER     8'h15
`define APCD_OFS_FRAC_HIGH   8'h16
`define APCD_OFS_FRAC_LOW    8'h17
`define APCD_OFS_R_FACTOR    8'h18
`define APCD_OFS_CORE_DIV    8'h1b
`define APCD_OFS_CONV_DIV    8'h1c
`define APCD_OFS_CP_DIV      8'h1d
`define APCD_OFS_OSR_DIV     8'h1e
`define APCD_OFS_BCLK_DIV    8'h20
`define APCD_OFS_FRAME_DIV   8'h21

// Field upper bits (all fields start at bit 0)
`define APCD_FRAC_HIGH_MSB   5
`define APCD_FRAC_LOW_MSB    7
`define APCD_NIBBLE_MSB      3
`define APCD_INTEGER_MSB     5
`define APCD_DIV7_MSB        6
`define APCD_FRAME_MSB       7

// Reset values
`define APCD_RST_PREDIV      4'h0
`define APCD_RST_INTEGER     6'h08
`define APCD_RST_FRAC_HIGH   6'h00
`define APCD_RST_FRAC_LOW    8'h00
`define APCD_RST_R_FACTOR    4'h0
`define APCD_RST_CORE_DIV    7'h00
`define APCD_RST_CONV_DIV    7'h01
`define APCD_RST_CP_DIV      7'h01
`define APCD_RST_OSR_DIV     7'h01
`define APCD_RST_BCLK_DIV    7'h00
`define APCD_RST_FRAME_DIV   8'h00

// Largest legal fraction and fraction scale
`define APCD_FRAC_MAX        14'h270f
`define APCD_FRAC_SCALE      24'h002710

// Settings used while automatic clock setup is active
`define APCD_AUTO_INTEGER    6'h08
`define APCD_AUTO_FRAC       14'h0000
`define APCD_AUTO_R_FACTOR   4'h0
`define APCD_AUTO_PREDIV     4'h0
`define APCD_AUTO_CORE_DIV   7'h00
`define APCD_AUTO_CONV_DIV   7'h01
`define APCD_AUTO_CP_DIV     7'h01
`define APCD_AUTO_OSR_DIV    7'h01

`endif

/* include/apcd_pkg.sv */
// Types shared by the audio clock block
package apcd_pkg;

    // Divider counter state
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] lat;
        logic       tick;
    } apcd_div_state_type;

    // Register file and output state
    typedef struct packed {
        logic [5:0]  frac_hi;
        logic [7:0]  frac_lo;
        logic [3:0]  r_fld;
        logic [5:0]  j_fld;
        logic [3:0]  p_fld;
        logic [6:0]  core;
        logic [6:0]  conv;
        logic [6:0]  cp;
        logic [6:0]  osr;
        logic [6:0]  bclk;
        logic [7:0]  frame;
        logic [7:0]  rdata;
        logic [5:0]  pll_j;
        logic [13:0] pll_d;
        logic [4:0]  pll_r;
        logic [4:0]  pll_p;
        logic [23:0] mult;
        logic        frac_bad;
    } apcd_state_type;

endpackage

/* hdl/apcd_divider.sv */
// Integer tick divider that takes a new ratio only at terminal count
`timescale 1ns/100ps
module apcd_divider
    import apcd_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic       i_clk_en,
    input  wire logic       i_src_tick,
    input  wire logic [7:0] i_code,
    output logic            o_tick,
    output logic [7:0]      o_ratio
);

    apcd_div_state_type s_reg;
    apcd_div_state_type s_next;

    // Count source ticks up to the latched code
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (i_src_tick) begin
            if (s_reg.cnt == s_reg.lat) begin
                s_next.tick = 1'b1;
                s_next.cnt  = 8'h00;
                s_next.lat  = i_code;
            end else begin
                s_next.cnt = s_reg.cnt + 8'h01;
            end
        end
    end

    // State register, frozen by clock enable
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else if (i_clk_en) begin
            s_reg <= s_next;
        end
    end

    assign o_tick  = s_reg.tick;
    assign o_ratio = s_reg.lat;

endmodule

/* hdl/apcd_clock_gen.sv */
// Audio PLL factor registers and clock dividers
//
// Operation
// - The fraction is 14 bits, six high bits in one register and eight low in the next.
// - The PLL multiplication equals J with fraction D, times R.
// - The R factor is its 4-bit code plus one, 1 to 16.
// - In automatic clock setup the written factors and the core, converter, charge-pump and oversampling dividers are disregarded.
// - The core clock is its source divided by its 7-bit code plus one.
// - The converter clock is its source divided by its 7-bit code plus one.
// - The charge-pump clock is its source divided by its 7-bit code plus one.
// - The oversampling clock is its source divided by its 7-bit code plus one.
// - In master mode the bit clock is the master clock divided by its code plus one.
// - The integer factor J equals its 6-bit code directly.
// - The pre-divider P is its 4-bit code plus one.
// - In master mode the frame clock is the bit clock divided by its 8-bit code plus one.
`timescale 1ns/100ps
`include "apcd_consts.svh"
module apcd_clock_gen
    import apcd_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_clk_en,
    input  wire logic        i_auto_mode,
    input  wire logic        i_master_mode,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_core_src_tick,
    input  wire logic        i_conv_src_tick,
    input  wire logic        i_cp_src_tick,
    input  wire logic        i_osr_src_tick,
    input  wire logic        i_mclk_tick,
    output logic [7:0]       o_reg_rdata,
    output logic [5:0]       o_pll_j,
    output logic [13:0]      o_pll_d,
    output logic [4:0]       o_pll_r,
    output logic [4:0]       o_pll_p,
    output logic [23:0]      o_pll_mult,
    output logic             o_frac_illegal,
    output logic             o_core_tick,
    output logic             o_conv_tick,
    output logic             o_charge_pump_clock_tick,
    output logic             o_osr_tick,
    output logic             o_bclk_tick,
    output logic             o_frame_tick
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Code plus one for 4-bit factors
    function automatic logic [4:0] plus_one4(input logic [3:0] code);
        plus_one4 = {1'b0, code} + 5'h01;
    endfunction
    // Widen a 7-bit divider code
    function automatic logic [7:0] widen7(input logic [6:0] code);
        widen7 = {1'b0, code};
    endfunction
    // Scaled product (J * 10000 + D) * R
    function automatic logic [23:0] pll_product(
        input logic [5:0]  j,
        input logic [13:0] d,
        input logic [4:0]  r
    );
        logic [23:0] base;
        base        = 24'(24'(j) * `APCD_FRAC_SCALE) + 24'(d);
        pll_product = 24'(base * 24'(r));
    endfunction
    localparam apcd_state_type ST_RST = '{
        frac_hi:  `APCD_RST_FRAC_HIGH,
        frac_lo:  `APCD_RST_FRAC_LOW,
        r_fld:    `APCD_RST_R_FACTOR,
        j_fld:    `APCD_RST_INTEGER,
        p_fld:    `APCD_RST_PREDIV,
        core:     `APCD_RST_CORE_DIV,
        conv:     `APCD_RST_CONV_DIV,
        cp:       `APCD_RST_CP_DIV,
        osr:      `APCD_RST_OSR_DIV,
        bclk:     `APCD_RST_BCLK_DIV,
        frame:    `APCD_RST_FRAME_DIV,
        rdata:    8'h00,
        pll_j:    `APCD_RST_INTEGER,
        pll_d:    14'h0000,
        pll_r:    5'h01,
        pll_p:    5'h01,
        mult:     24'h013880,
        frac_bad: 1'b0
    };

    apcd_state_type s_reg;
    apcd_state_type s_next;
    logic [13:0] frac_word;
    logic [5:0]  eff_j;
    logic [13:0] eff_d;
    logic [3:0]  eff_r;
    logic [3:0]  eff_p;
    logic [7:0]  core_code;
    logic [7:0]  conv_code;
    logic [7:0]  cp_code;
    logic [7:0]  osr_code;
    logic        bclk_src;
    logic [7:0]  core_lat;
    logic [7:0]  conv_lat;
    logic [7:0]  cp_lat;
    logic [7:0]  osr_lat;
    logic [7:0]  bclk_lat;
    logic [7:0]  frame_lat;

    ////////////////////////////////////////////////////////////////////////////
    // Effective settings

    assign frac_word = {s_reg.frac_hi, s_reg.frac_lo};

    always_comb begin
        if (i_auto_mode) begin
            eff_j     = `APCD_AUTO_INTEGER;
            eff_d     = `APCD_AUTO_FRAC;
            eff_r     = `APCD_AUTO_R_FACTOR;
            eff_p     = `APCD_AUTO_PREDIV;
            core_code = widen7(`APCD_AUTO_CORE_DIV);
            conv_code = widen7(`APCD_AUTO_CONV_DIV);
            cp_code   = widen7(`APCD_AUTO_CP_DIV);
            osr_code  = widen7(`APCD_AUTO_OSR_DIV);
        end else begin
            eff_j     = s_reg.j_fld;
            eff_d     = frac_word;
            eff_r     = s_reg.r_fld;
            eff_p     = s_reg.p_fld;
            core_code = widen7(s_reg.core);
            conv_code = widen7(s_reg.conv);
            cp_code   = widen7(s_reg.cp);
            osr_code  = widen7(s_reg.osr);
        end
    end

    // bit clock only in master mode
    assign bclk_src = i_mclk_tick & i_master_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Register file and PLL outputs

    always_comb begin
        s_next = s_reg;
        // Register writes keep field bits only
        if (i_reg_wr) begin
            case (i_reg_addr)
                `APCD_OFS_PREDIV:    s_next.p_fld   = i_reg_wdata[`APCD_NIBBLE_MSB:0];
                `APCD_OFS_INTEGER:   s_next.j_fld   = i_reg_wdata[`APCD_INTEGER_MSB:0];
                `APCD_OFS_FRAC_HIGH: s_next.frac_hi = i_reg_wdata[`APCD_FRAC_HIGH_MSB:0];
                `APCD_OFS_FRAC_LOW:  s_next.frac_lo = i_reg_wdata[`APCD_FRAC_LOW_MSB:0];
                `APCD_OFS_R_FACTOR:  s_next.r_fld   = i_reg_wdata[`APCD_NIBBLE_MSB:0];
                `APCD_OFS_CORE_DIV:  s_next.core    = i_reg_wdata[`APCD_DIV7_MSB:0];
                `APCD_OFS_CONV_DIV:  s_next.conv    = i_reg_wdata[`APCD_DIV7_MSB:0];
                `APCD_OFS_CP_DIV:    s_next.cp      = i_reg_wdata[`APCD_DIV7_MSB:0];
                `APCD_OFS_OSR_DIV:   s_next.osr     = i_reg_wdata[`APCD_DIV7_MSB:0];
                `APCD_OFS_BCLK_DIV:  s_next.bclk    = i_reg_wdata[`APCD_DIV7_MSB:0];
                `APCD_OFS_FRAME_DIV: s_next.frame   = i_reg_wdata[`APCD_FRAME_MSB:0];
                default:             s_next.frame   = s_reg.frame;
            endcase
        end
        // Read data, reserved bits and unmapped offsets give zero
        if (i_reg_rd) begin
            case (i_reg_addr)
                `APCD_OFS_PREDIV:    s_next.rdata = {4'h0, s_reg.p_fld};
                `APCD_OFS_INTEGER:   s_next.rdata = {2'h0, s_reg.j_fld};
                `APCD_OFS_FRAC_HIGH: s_next.rdata = {2'h0, s_reg.frac_hi};
                `APCD_OFS_FRAC_LOW:  s_next.rdata = s_reg.frac_lo;
                `APCD_OFS_R_FACTOR:  s_next.rdata = {4'h0, s_reg.r_fld};
                `APCD_OFS_CORE_DIV:  s_next.rdata = widen7(s_reg.core);
                `APCD_OFS_CONV_DIV:  s_next.rdata = widen7(s_reg.conv);
                `APCD_OFS_CP_DIV:    s_next.rdata = widen7(s_reg.cp);
                `APCD_OFS_OSR_DIV:   s_next.rdata = widen7(s_reg.osr);
                `APCD_OFS_BCLK_DIV:  s_next.rdata = widen7(s_reg.bclk);
                `APCD_OFS_FRAME_DIV: s_next.rdata = s_reg.frame;
                default:             s_next.rdata = 8'h00;
            endcase
        end
        s_next.pll_j    = eff_j;
        s_next.pll_d    = eff_d;
        s_next.pll_r    = plus_one4(eff_r);
        s_next.pll_p    = plus_one4(eff_p);
        s_next.mult     = pll_product(eff_j, eff_d, plus_one4(eff_r));
        s_next.frac_bad = (eff_d > `APCD_FRAC_MAX);
    end

    // State register, frozen by clock enable
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= ST_RST;
        end else if (i_clk_en) begin
            s_reg <= s_next;
        end
    end

    assign o_reg_rdata    = s_reg.rdata;
    assign o_pll_j        = s_reg.pll_j;
    assign o_pll_d        = s_reg.pll_d;
    assign o_pll_r        = s_reg.pll_r;
    assign o_pll_p        = s_reg.pll_p;
    assign o_pll_mult     = s_reg.mult;
    assign o_frac_illegal = s_reg.frac_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Dividers

    apcd_divider u_core_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .i_src_tick (i_core_src_tick),
        .i_code     (core_code),
        .o_tick     (o_core_tick),
        .o_ratio    (core_lat)
    );

    apcd_divider u_conv_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .i_src_tick (i_conv_src_tick),
        .i_code     (conv_code),
        .o_tick     (o_conv_tick),
        .o_ratio    (conv_lat)
    );

    apcd_divider u_cp_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .i_src_tick (i_cp_src_tick),
        .i_code     (cp_code),
        .o_tick     (o_charge_pump_clock_tick),
        .o_ratio    (cp_lat)
    );

    apcd_divider u_osr_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .i_src_tick (i_osr_src_tick),
        .i_code     (osr_code),
        .o_tick     (o_osr_tick),
        .o_ratio    (osr_lat)
    );

    apcd_divider u_bclk_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .i_src_tick (bclk_src),
        .i_code     (widen7(s_reg.bclk)),
        .o_tick     (o_bclk_tick),
        .o_ratio    (bclk_lat)
    );

    apcd_divider u_frame_div (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_clk_en   (i_clk_en),
        .i_src_tick (o_bclk_tick & i_master_mode),
        .i_code     (s_reg.frame),
        .o_tick     (o_frame_tick),
        .o_ratio    (frame_lat)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    frac_join_a: assert property (
        (i_clk_en && !i_auto_mode) |=> o_pll_d == $past(frac_word))
        else $error("fraction not joined from both halves");
    mult_value_a: assert property (
        (i_clk_en && !i_auto_mode) |=>
        o_pll_mult == pll_product($past(s_reg.j_fld), $past(frac_word),
                                  plus_one4($past(s_reg.r_fld))))
        else $error("PLL product wrong");
    r_plus_a: assert property (
        (i_clk_en && !i_auto_mode) |=> o_pll_r == plus_one4($past(s_reg.r_fld)))
        else $error("R factor not code plus one");
    auto_override_a: assert property (
        (i_clk_en && i_auto_mode) |=>
        (o_pll_j == `APCD_AUTO_INTEGER && o_pll_d == `APCD_AUTO_FRAC))
        else $error("manual factors used in auto mode");
    core_unity_a: assert property (
        (i_clk_en && i_core_src_tick && core_lat == 8'h00) |=> o_core_tick)
        else $error("core divide by one missed");
    conv_source_a: assert property (
        (o_conv_tick && $past(i_clk_en)) |-> $past(i_conv_src_tick))
        else $error("converter tick without source");
    cp_unity_a: assert property (
        (i_clk_en && i_cp_src_tick && cp_lat == 8'h00) |=> o_charge_pump_clock_tick)
        else $error("charge-pump divide by one missed");
    osr_source_a: assert property (
        (o_osr_tick && $past(i_clk_en)) |-> $past(i_osr_src_tick))
        else $error("oversampling tick without source");
    bclk_slave_a: assert property (
        (i_clk_en && !i_master_mode) |=> !o_bclk_tick)
        else $error("bit clock outside master mode");
    j_direct_a: assert property (
        (i_clk_en && !i_auto_mode) |=> o_pll_j == $past(s_reg.j_fld))
        else $error("J not taken directly");
    p_plus_a: assert property (
        (i_clk_en && !i_auto_mode) |=> o_pll_p == plus_one4($past(s_reg.p_fld)))
        else $error("P not code plus one");
    frame_source_a: assert property (
        (o_frame_tick && $past(i_clk_en)) |-> ($past(o_bclk_tick) && $past(i_master_mode)))
        else $error("frame tick without bit clock");
    ratio_swap_a: assert property (
        ($changed(core_lat) || $changed(bclk_lat) || $changed(frame_lat)) |->
        (o_core_tick || o_bclk_tick || o_frame_tick))
        else $error("ratio changed away from terminal count");
    core_run_c:   cover property (o_core_tick ##[1:200] o_core_tick);
    frame_run_c:  cover property (i_master_mode && o_frame_tick);
    auto_swap_c:  cover property ($rose(i_auto_mode) ##1 o_pll_j == `APCD_AUTO_INTEGER);
    ratio_new_c:  cover property ($changed(conv_lat) || $changed(cp_lat) || $changed(osr_lat));

endmodule

/* tb/tb.sv */
// Self-checking testbench for the audio PLL factor registers and clock dividers
`timescale 1ns/100ps
module tb
    import apcd_pkg::*;
;
    logic        i_clk_sys;
    logic        i_rst_n;
    logic        i_clk_en;
    logic        i_auto_mode;
    logic        i_master_mode;
    logic        i_reg_wr;
    logic        i_reg_rd;
    logic [7:0]  i_reg_addr;
    logic [7:0]  i_reg_wdata;
    logic [4:0]  src;
    logic [7:0]  o_reg_rdata;
    logic [5:0]  o_pll_j;
    logic [13:0] o_pll_d;
    logic [4:0]  o_pll_r;
    logic [4:0]  o_pll_p;
    logic [23:0] o_pll_mult;
    logic        o_frac_illegal;
    logic [5:0]  ticks;
    int          fail_count;
    int          total_checks;
    logic [7:0]  ofs_tab [11] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1b, 8'h1c, 8'h1d,
                                  8'h1e, 8'h20, 8'h21};
    logic [7:0]  rst_tab [11] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
                                  8'h01, 8'h00, 8'h00};
    logic [7:0]  msk_tab [11] = '{8'h0f, 8'h3f, 8'h3f, 8'hff, 8'h0f, 8'h7f, 8'h7f, 8'h7f,
                                  8'h7f, 8'h7f, 8'hff};

    apcd_clock_gen u_dut (
        .i_clk_sys                (i_clk_sys),
        .i_rst_n                  (i_rst_n),
        .i_clk_en                 (i_clk_en),
        .i_auto_mode              (i_auto_mode),
        .i_master_mode            (i_master_mode),
        .i_reg_wr                 (i_reg_wr),
        .i_reg_rd                 (i_reg_rd),
        .i_reg_addr               (i_reg_addr),
        .i_reg_wdata              (i_reg_wdata),
        .i_core_src_tick          (src[0]),
        .i_conv_src_tick          (src[1]),
        .i_cp_src_tick            (src[2]),
        .i_osr_src_tick           (src[3]),
        .i_mclk_tick              (src[4]),
        .o_reg_rdata              (o_reg_rdata),
        .o_pll_j                  (o_pll_j),
        .o_pll_d                  (o_pll_d),
        .o_pll_r                  (o_pll_r),
        .o_pll_p                  (o_pll_p),
        .o_pll_mult               (o_pll_mult),
        .o_frac_illegal           (o_frac_illegal),
        .o_core_tick              (ticks[0]),
        .o_conv_tick              (ticks[1]),
        .o_charge_pump_clock_tick (ticks[2]),
        .o_osr_tick               (ticks[3]),
        .o_bclk_tick              (ticks[4]),
        .o_frame_tick             (ticks[5])
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compare one value, count and report
    task check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One-cycle write strobe, launched at the falling edge
    task reg_write(input logic [7:0] addr, input logic [7:0] data);
        i_reg_wr    = 1'b1;
        i_reg_addr  = addr;
        i_reg_wdata = data;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
        @(negedge i_clk_sys);
    endtask

    // One-cycle read strobe, data sampled one edge later
    task reg_read(input logic [7:0] addr, input logic [7:0] exp);
        i_reg_rd   = 1'b1;
        i_reg_addr = addr;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        check({16'h0000, o_reg_rdata}, {16'h0000, exp}, "register read");
        @(negedge i_clk_sys);
    endtask

    // Let written factors reach the PLL outputs, then compare them
    task pll_check(input logic [5:0] j, input logic [13:0] d, input logic [4:0] r,
                   input logic [4:0] p, input logic [23:0] mult, input logic bad);
        repeat (2) @(negedge i_clk_sys);
        check({18'h0, o_pll_j}, {18'h0, j}, "pll integer");
        check({10'h0, o_pll_d}, {10'h0, d}, "pll fraction");
        check({19'h0, o_pll_r}, {19'h0, r}, "pll r factor");
        check({19'h0, o_pll_p}, {19'h0, p}, "pll prediv");
        check(o_pll_mult, mult, "pll multiplication");
        check({23'h0, o_frac_illegal}, {23'h0, bad}, "fraction flag");
    endtask

    // Write a divider code, feed its source every cycle, time the settled period
    task measure(input int idx, input logic [7:0] ofs, input logic [7:0] code,
                 input int expn);
        int seen;
        int t2;
        int n;
        reg_write(ofs, code);
        seen = 0;
        t2   = 0;
        n    = 0;
        src[(idx == 5) ? 4 : idx] = 1'b1;
        while (seen < 3 && n < 1200) begin
            @(negedge i_clk_sys);
            n++;
            if (ticks[idx] === 1'b1) begin
                seen++;
                if (seen == 2) begin
                    t2 = n;
                end
            end
        end
        src = 5'h00;
        if (seen < 3) begin
            fail_count++;
            $display("mismatch at %0t: divider output never came", $time);
            tally_and_finish();
        end
        check(24'(n - t2), 24'(expn), "divider period");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int k;
        int bc;
        fail_count    = 0;
        total_checks  = 0;
        i_rst_n       = 1'b0;
        i_clk_en      = 1'b1;
        i_auto_mode   = 1'b0;
        i_master_mode = 1'b1;
        i_reg_wr      = 1'b0;
        i_reg_rd      = 1'b0;
        i_reg_addr    = 8'h00;
        i_reg_wdata   = 8'h00;
        src           = 5'h00;
        repeat (16) @(negedge i_clk_sys);
        i_rst_n = 1'b1;

        // Reset values, field masks and unmapped offset
        pll_check(6'h08, 14'h0000, 5'h01, 5'h01, 24'h013880, 1'b0);
        for (k = 0; k < 11; k++) begin
            reg_read(ofs_tab[k], rst_tab[k]);
            reg_write(ofs_tab[k], 8'hff);
            reg_read(ofs_tab[k], msk_tab[k]);
            reg_write(ofs_tab[k], rst_tab[k]);
        end
        reg_write(8'h19, 8'hff);
        reg_read(8'h19, 8'h00);
        i_clk_en = 1'b0;
        reg_write(8'h1b, 8'h55);
        i_clk_en = 1'b1;
        reg_read(8'h1b, 8'h00);
        $display("test registers done");

        // Fraction split over two registers, R code plus one, J and P
        reg_write(8'h15, 8'h3f);
        reg_write(8'h14, 8'h0e);
        reg_write(8'h16, 8'h27);
        reg_write(8'h17, 8'h0f);
        reg_write(8'h18, 8'h0f);
        pll_check(6'h3f, 14'h270f, 5'h10, 5'h0f, 24'h9c3ff0, 1'b0);
        reg_write(8'h17, 8'h10);
        pll_check(6'h3f, 14'h2710, 5'h10, 5'h0f, 24'h9c4000, 1'b1);
        reg_write(8'h17, 8'h0f);
        $display("test pll factors done");

        // Automatic setup overrides manual factors and the core and converter divider codes
        i_auto_mode = 1'b1;
        pll_check(6'h08, 14'h0000, 5'h01, 5'h01, 24'h013880, 1'b0);
        measure(0, 8'h1b, 8'h05, 1);
        measure(1, 8'h1c, 8'h05, 2);
        i_auto_mode = 1'b0;
        pll_check(6'h3f, 14'h270f, 5'h10, 5'h0f, 24'h9c3ff0, 1'b0);
        $display("test auto mode done");

        // Divider ratios at boundary and mid-range codes
        measure(0, 8'h1b, 8'h05, 6);
        measure(0, 8'h1b, 8'h7f, 128);
        measure(0, 8'h1b, 8'h00, 1);
        measure(1, 8'h1c, 8'h7f, 128);
        measure(1, 8'h1c, 8'h00, 1);
        measure(2, 8'h1d, 8'h02, 3);
        measure(2, 8'h1d, 8'h7f, 128);
        measure(3, 8'h1e, 8'h00, 1);
        measure(3, 8'h1e, 8'h7f, 128);
        measure(4, 8'h20, 8'h03, 4);
        measure(4, 8'h20, 8'h7f, 128);
        measure(4, 8'h20, 8'h00, 1);
        measure(5, 8'h21, 8'hff, 256);
        measure(5, 8'h21, 8'h02, 3);
        $display("test dividers done");

        // Bit clock silent outside master mode
        i_master_mode = 1'b0;
        bc = 0;
        @(negedge i_clk_sys);
        src[4] = 1'b1;
        repeat (40) begin
            @(negedge i_clk_sys);
            if (ticks[4] !== 1'b0) begin
                bc++;
            end
        end
        src = 5'h00;
        check(24'(bc), 24'h000000, "bit clock outside master mode");
        $display("test master gating done");
        tally_and_finish();
    end
endmodule
